// ---- hdl/mtr_readout.sv ----
// conversion sequencer and value registers of the monitor readout
// Overview of operation
// - every result is an 8-bit code from one shared multiplexed converter; temperatures are signed.
// - attenuated supply channels convert their nominal voltage to code 192.
// - one ordinary voltage channel is converted every 748 us while running.
// - each remote diode reading is the average of 16 successive conversions.
// - local temperature goes to 27h, its extra low bits to bits 7:6 of 4Bh.
// - local temperature is two's complement, one degree per step.
// - the first remote diode channel is always measured as temperature.
// - the second pin pair is a diode channel only when channel mode bit 2 is 1.
// - averaged remote results are stored as 8-bit two's complement bytes.
// - all channel mode bits are zero after reset.
// - conversion runs while config bit 0 is 1 and bit 3 is 0, and stops on 0.
// - enabled channels are converted in turn, each result stored when done.
`timescale 1ns/1ps
`default_nettype none
`include "mtr_defines.svh"
module mtr_readout
  import mtr_pkg::*;
#(
  parameter int CONV_CYC = `MTR_CONV_CYC,
  parameter int REM_CYC  = `MTR_REM_CYC
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register access
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // converter front end
  output logic            adc_start,
  output logic      [3:0] adc_chan,
  input  wire logic       adc_done,
  input  wire logic [7:0] adc_code,
  input  wire logic [1:0] adc_lsb,
  // status
  output logic            busy
);

  function automatic logic chan_en(input logic [3:0] c, input logic [7:0] m);
    unique case (c)
      CH_GENERAL_ANALOG_INPUT_ONE:           chan_en = m[`MTR_CHM_GENERAL_ANALOG_INPUT_ONE_BIT];
      CH_GENERAL_ANALOG_INPUT_TWO:           chan_en = m[`MTR_CHM_GENERAL_ANALOG_INPUT_TWO_BIT];
      CH_V25, CH_SECOND_CORE_SUPPLY_INPUT:  chan_en = !m[`MTR_CHM_REM2_BIT];
      CH_REM2:           chan_en = m[`MTR_CHM_REM2_BIT];
      CH_REM1:           chan_en = 1'b1;
      default:           chan_en = (c < 4'(`MTR_NUM_CH));
    endcase
  endfunction

  function automatic logic [3:0] next_chan(input logic [3:0] c,
                                           input logic [7:0] m);
    logic [3:0] n;
    logic       hit;
    logic [4:0] s;
    n   = c;
    hit = 1'b0;
    s   = '0;
    for (int i = 1; i <= `MTR_NUM_CH; i++)
      if (!hit)
      begin
        s   = 5'(c) + 5'(i);
        n   = (s >= 5'(`MTR_NUM_CH)) ? 4'(s - 5'(`MTR_NUM_CH)) : 4'(s);
        hit = chan_en(n, m);
      end
    next_chan = n;
  endfunction

  function automatic logic is_rem(input logic [3:0] c);
    is_rem = (c == CH_REM1) || (c == CH_REM2);
  endfunction

  // sequencer state
  mtr_state_t  st_r, st_nxt;
  logic [3:0]  chan_r, chan_nxt;
  logic [16:0] tmr_r, tmr_nxt;
  logic        got_r, got_nxt;
  logic [7:0]  code_r, code_nxt;
  logic [1:0]  frac_r, frac_nxt;
  logic [11:0] acc_r, acc_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        start_r, start_nxt;
  // registers
  logic [7:0]  cfg_r, chmode_r, tcfg_r;
  logic [7:0]  val_r [`MTR_NUM_CH];
  logic [7:0]  rdata_r;
  logic        run, store;
  logic [11:0] sum;
  logic [7:0]  result;

  assign run = cfg_r[`MTR_CFG_START_BIT] & ~cfg_r[`MTR_CFG_CLR_BIT];
  // signed sum of the previous fifteen plus the last sample
  assign sum = acc_r + {{4{code_r[7]}}, code_r};
  // floor of sum/16 keeps sign and one degree per code
  assign result = is_rem(chan_r) ? sum[11:4] : code_r;

  always_comb
  begin
    st_nxt    = st_r;
    chan_nxt  = chan_r;
    tmr_nxt   = tmr_r;
    got_nxt   = got_r;
    code_nxt  = code_r;
    frac_nxt  = frac_r;
    acc_nxt   = acc_r;
    cnt_nxt   = cnt_r;
    start_nxt = 1'b0;
    store     = 1'b0;
    unique case (st_r)
      ST_IDLE:
      begin
        if (run)
        begin
          chan_nxt  = next_chan(4'(`MTR_NUM_CH - 1), chmode_r);
          st_nxt    = ST_CONV;
          start_nxt = 1'b1;
          got_nxt   = 1'b0;
          acc_nxt   = '0;
          cnt_nxt   = '0;
          tmr_nxt   = is_rem(chan_nxt) ? 17'(REM_CYC - 1)
                                       : 17'(CONV_CYC - 1);
        end
      end
      ST_CONV:
      begin
        // an abandoned conversion is discarded, never half stored
        if (!run)
          st_nxt = ST_IDLE;
        else
        begin
          if (tmr_r != '0)
            tmr_nxt = tmr_r - 17'd1;
          if (adc_done && !got_r)
          begin
            got_nxt  = 1'b1;
            code_nxt = adc_code;
            frac_nxt = adc_lsb;
          end
          if (tmr_r == '0 && got_r)
          begin
            start_nxt = 1'b1;
            got_nxt   = 1'b0;
            if (is_rem(chan_r) && cnt_r != 4'(`MTR_REM_AVG - 1))
            begin
              acc_nxt = sum;
              cnt_nxt = cnt_r + 4'd1;
              tmr_nxt = 17'(REM_CYC - 1);
            end
            else
            begin
              store    = 1'b1;
              acc_nxt  = '0;
              cnt_nxt  = '0;
              chan_nxt = next_chan(chan_r, chmode_r);
              tmr_nxt  = is_rem(chan_nxt) ? 17'(REM_CYC - 1)
                                          : 17'(CONV_CYC - 1);
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r    <= ST_IDLE;
      chan_r  <= '0;
      tmr_r   <= '0;
      got_r   <= 1'b0;
      code_r  <= '0;
      frac_r  <= '0;
      acc_r   <= '0;
      cnt_r   <= '0;
      start_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      chan_r  <= chan_nxt;
      tmr_r   <= tmr_nxt;
      got_r   <= got_nxt;
      code_r  <= code_nxt;
      frac_r  <= frac_nxt;
      acc_r   <= acc_nxt;
      cnt_r   <= cnt_nxt;
      start_r <= start_nxt;
    end
  end

  // supply scaling lives in the analog attenuators; codes pass unchanged
  assign adc_start = start_r;
  assign adc_chan  = chan_r;
  assign busy      = (st_r == ST_CONV);

  // register file
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_r    <= `MTR_CFG_RST;
      chmode_r <= `MTR_CHMODE_RST;
      tcfg_r   <= `MTR_TCFG_RST;
      for (int i = 0; i < `MTR_NUM_CH; i++)
        val_r[i] <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == `MTR_OFS_CFG)
        cfg_r <= reg_wdata;
      if (reg_wr && reg_addr == `MTR_OFS_CHMODE)
        chmode_r <= reg_wdata;
      // bits 7:6 belong to the converter; a host write changes only bits 5:0
      if (store && chan_r == CH_LOCAL)
        tcfg_r[7:6] <= frac_r;
      if (reg_wr && reg_addr == `MTR_OFS_TCFG)
        tcfg_r[5:0] <= reg_wdata[5:0];
      if (store)
        val_r[chan_r] <= result;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= '0;
    else if (reg_addr >= `MTR_OFS_VAL_BASE &&
             reg_addr < `MTR_OFS_VAL_BASE + 8'(`MTR_NUM_CH))
      rdata_r <= val_r[4'(reg_addr - `MTR_OFS_VAL_BASE)];
    else if (reg_addr == `MTR_OFS_CFG)
      rdata_r <= cfg_r;
    else if (reg_addr == `MTR_OFS_CHMODE)
      rdata_r <= chmode_r;
    else if (reg_addr == `MTR_OFS_TCFG)
      rdata_r <= tcfg_r;
    else
      rdata_r <= '0;
  end
  assign reg_rdata = rdata_r;

  // assertions
  logic [16:0] since_start;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      since_start <= '0;
    else if (start_r)
      since_start <= 17'd1;
    else if (since_start != '1)
      since_start <= since_start + 17'd1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence stop_seen;
    st_r == ST_CONV && !run;
  endsequence
  sequence quiet_idle;
    st_r == ST_IDLE && !adc_start ##1 (!adc_start || $past(run));
  endsequence

  AST_STOP_HALTS: assert property (stop_seen |=> quiet_idle)
    else $error("conversion did not stop");
  AST_START_ON_RUN: assert property (
      st_r == ST_IDLE && run |=> adc_start)
    else $error("run did not start conversion");
  AST_VOLT_SPACING: assert property (store && !is_rem(chan_r)
      |-> since_start >= 17'(CONV_CYC - 1))
    else $error("voltage slot shorter than interval");
  AST_REM_SIXTEEN: assert property (store && is_rem(chan_r)
      |-> cnt_r == 4'hf && since_start >= 17'(REM_CYC - 1))
    else $error("remote result before sixteen conversions");
  AST_LOCAL_STORE: assert property (store && chan_r == CH_LOCAL
      |=> val_r[CH_LOCAL] == $past(code_r) && tcfg_r[7:6] == $past(frac_r))
    else $error("local temperature not stored");
  AST_REM_AVG: assert property (store && is_rem(chan_r)
      |=> val_r[$past(chan_r)] == $past(sum[11:4]))
    else $error("remote average wrong");
  AST_PAIR_MODE: assert property (adc_start
      |-> (adc_chan != CH_REM2 || $past(chmode_r[2])) &&
          ((adc_chan != CH_V25 && adc_chan != CH_SECOND_CORE_SUPPLY_INPUT) ||
           !$past(chmode_r[2])))
    else $error("second pair measured in wrong mode");
  AST_REM1_ALWAYS: assert property (store && (chan_r == CH_GENERAL_ANALOG_INPUT_TWO ||
      (chan_r == CH_LOCAL && !chmode_r[`MTR_CHM_GENERAL_ANALOG_INPUT_TWO_BIT]))
      |=> adc_start && chan_r == CH_REM1)
    else $error("first remote diode skipped");
  AST_NO_STORE_IDLE: assert property (st_r == ST_IDLE
      |-> (!store && $stable(val_r[CH_LOCAL])) [*2])
    else $error("value changed while idle");

endmodule // mtr_readout
`default_nettype wire

// ---- hdl/mtr_defines.svh ----
// register offsets, reset values and timing counts of the monitor readout
`ifndef MTR_DEFINES_SVH
`define MTR_DEFINES_SVH
`define MTR_CLK_MHZ        100
`define MTR_CONV_TIME_US   748
`define MTR_CONV_CYC       (`MTR_CONV_TIME_US * `MTR_CLK_MHZ)
`define MTR_REM_TIME_US    9600
`define MTR_REM_AVG        16
`define MTR_REM_CYC        ((`MTR_REM_TIME_US * `MTR_CLK_MHZ) / `MTR_REM_AVG)
`define MTR_OFS_VAL_BASE   8'h20
`define MTR_OFS_LOCAL_TEMP 8'h27
`define MTR_OFS_CFG        8'h40
`define MTR_OFS_CHMODE     8'h47
`define MTR_OFS_TCFG       8'h4b
`define MTR_CFG_RST        8'h00
`define MTR_CHMODE_RST     8'h00
`define MTR_TCFG_RST       8'h00
`define MTR_CFG_START_BIT  0
`define MTR_CFG_CLR_BIT    3
`define MTR_CHM_GENERAL_ANALOG_INPUT_ONE_BIT   0
`define MTR_CHM_GENERAL_ANALOG_INPUT_TWO_BIT   1
`define MTR_CHM_REM2_BIT   2
`define MTR_NUM_CH         11
`endif

// ---- hdl/mtr_pkg.sv ----
// types of the monitor readout
package mtr_pkg;
  typedef enum logic [3:0] {
    CH_V25, CH_VCCP1, CH_VCC, CH_V5, CH_V12, CH_SECOND_CORE_SUPPLY_INPUT, CH_GENERAL_ANALOG_INPUT_ONE,
    CH_LOCAL, CH_GENERAL_ANALOG_INPUT_TWO, CH_REM1, CH_REM2
  } mtr_chan_t;
  typedef enum logic {ST_IDLE, ST_CONV} mtr_state_t;
endpackage

// ---- testbench/mtr_adc_model.sv ----
// front end model: answers each conversion start with a code
`timescale 1ns/1ps
`default_nettype none
module mtr_adc_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // converter handshake
  input  wire logic       adc_start,
  input  wire logic [3:0] adc_chan,
  input  wire logic [7:0] dly,
  output var  logic       adc_done,
  output var  logic [7:0] adc_code,
  output var  logic [1:0] adc_lsb
);
  logic [3:0] ch;
  logic [7:0] cnt;
  logic [3:0] k1;
  logic [3:0] k2;
  // remote codes vary so a stored last or first sample shows up
  function automatic logic [7:0] code_of(input logic [3:0] c);
    if (c == 4'h7)
      return 8'h81;
    if (c == 4'h9)
      return (k1 < 4'h8) ? 8'hce : 8'hd0;
    if (c == 4'ha)
      return 8'h18 + {6'h0, k2[1:0]};
    return 8'hc0 ^ {4'h0, c};
  endfunction
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      cnt <= 8'h00;
      ch <= 4'h0;
      k1 <= 4'h0;
      k2 <= 4'h0;
      adc_done <= 1'b0;
      adc_code <= 8'h5a;
      adc_lsb <= 2'b00;
    end
    else
    begin
      // idle data toggles so a stale sample never matches
      adc_done <= 1'b0;
      adc_code <= ~adc_code;
      adc_lsb <= ~adc_lsb;
      if (adc_start)
      begin
        ch <= adc_chan;
        cnt <= dly;
      end
      else if (cnt == 8'h01)
      begin
        adc_done <= 1'b1;
        adc_code <= code_of(ch);
        adc_lsb <= (ch == 4'h7) ? 2'b10 : 2'b01;
        k1 <= k1 + ((ch == 4'h9) ? 4'h1 : 4'h0);
        k2 <= k2 + ((ch == 4'ha) ? 4'h1 : 4'h0);
        cnt <= 8'h00;
      end
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
endmodule // mtr_adc_model
`default_nettype wire

// ---- testbench/mtr_readout_tb_top.sv ----
// register level bench of the monitor readout
`timescale 1ns/1ps
`default_nettype none
module mtr_readout_tb_top;
  localparam int CONV = 20;
  localparam int REM = 24;
  logic clk, reset_n, reg_wr, adc_start, adc_done, busy, slow, chk_on;
  logic have_prev = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, adc_code, dly, mode;
  logic [3:0] adc_chan;
  logic [3:0] prev = 4'h0;
  logic [1:0] adc_lsb;
  int error_cnt = 0, n_checks = 0, cyc = 0, gap = 0, n_start = 0, ns, i;
  int run_len = 0;
  mtr_readout #(.CONV_CYC(CONV), .REM_CYC(REM)) dut (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_done(adc_done), .adc_code(adc_code),
    .adc_lsb(adc_lsb), .busy(busy));
  mtr_adc_model fe (.clk(clk), .reset_n(reset_n), .adc_start(adc_start),
    .adc_chan(adc_chan), .dly(dly), .adc_done(adc_done),
    .adc_code(adc_code), .adc_lsb(adc_lsb));
  task summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    check(reg_rdata, e);
  endtask
  // the start pulse spans a whole cycle, so one falling edge sees it
  task wait_start(input logic [3:0] c);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (!(adc_start === 1'b1 && adc_chan === c) && k < 4000);
    check(8'(k >= 4000), 8'h00);
  endtask
  function automatic logic en(input logic [3:0] c, input logic [7:0] m);
    case (c)
      4'h0, 4'h5: return !m[2];
      4'h6: return m[0];
      4'h8: return m[1];
      4'ha: return m[2];
      default: return 1'b1;
    endcase
  endfunction
  function automatic logic [3:0] nxt(input logic [3:0] p, input logic [7:0] m);
    logic [3:0] c;
    c = p;
    repeat (11)
    begin
      c = (c == 4'ha) ? 4'h0 : c + 4'h1;
      if (en(c, m))
        return c;
    end
    return c;
  endfunction
  // remote channels repeat for each of their sixteen samples
  function automatic logic [3:0] exp_ch(input logic [3:0] p, input int n);
    return (p >= 4'h9 && n < 16) ? p : nxt(p, mode);
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    gap <= gap + 1;
    if (adc_start === 1'b1)
    begin
      n_start <= n_start + 1;
      gap <= 1;
      prev <= adc_chan;
      have_prev <= 1'b1;
      run_len <= (have_prev && adc_chan == prev) ? run_len + 1 : 1;
      if (chk_on && have_prev)
      begin
        check({4'h0, adc_chan}, {4'h0, exp_ch(prev, run_len)});
        if (!slow)
          check(8'(gap), 8'((prev >= 4'h9) ? REM : CONV));
        else
          check(8'(gap > 30), 8'h01);
      end
    end
    // a hung sequence counts as a failure
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    dly = 8'd3;
    slow = 1'b0;
    chk_on = 1'b0;
    mode = 8'h00;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    check({7'h0, busy}, 8'h00);
    rd(8'h47, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h4b, 8'h00);
    rd(8'h10, 8'h00);
    chk_on = 1'b1;
    wr(8'h40, 8'h01);
    wait_start(4'h0);
    check({7'h0, busy}, 8'h01);
    wait_start(4'h9);
    rd(8'h29, 8'h00);
    wait_start(4'h0);
    for (i = 0; i < 6; i++)
      rd(8'h20 + 8'(i), 8'hc0 ^ 8'(i));
    rd(8'h27, 8'h81);
    rd(8'h4b, 8'h80);
    rd(8'h29, 8'hcf);
    rd(8'h2a, 8'h00);
    wr(8'h27, 8'h00);
    rd(8'h27, 8'h81);
    wr(8'h4b, 8'hff);
    rd(8'h4b, 8'hbf);
    chk_on = 1'b0;
    mode = 8'h07;
    wr(8'h47, 8'h07);
    rd(8'h47, 8'h07);
    wait_start(4'ha);
    chk_on = 1'b1;
    wait_start(4'h1);
    rd(8'h2a, 8'h19);
    rd(8'h26, 8'hc6);
    rd(8'h28, 8'hc8);
    wait_start(4'ha);
    wait_start(4'h1);
    wr(8'h40, 8'h00);
    repeat (3) @(negedge clk);
    check({7'h0, busy}, 8'h00);
    chk_on = 1'b0;
    ns = n_start;
    wr(8'h40, 8'h09);
    repeat (60) @(negedge clk);
    check({7'h0, busy}, 8'h00);
    check(8'(n_start), 8'(ns));
    // late answers must hold off the next start
    slow = 1'b1;
    dly = 8'd30;
    wr(8'h40, 8'h01);
    wait_start(4'h2);
    chk_on = 1'b1;
    wait_start(4'h4);
    rd(8'h22, 8'hc2);
    summarize();
  end
endmodule // mtr_readout_tb_top
`default_nettype wire
